/* File: ccpc_consts.svh */
// Purpose: Constants for CPU clock and power control
// Assumes: 20 MHz aclk, 8-bit registers on 32-bit words
// Notes:   Offsets are byte addresses
`ifndef CCPC_CONSTS_SVH
`define CCPC_CONSTS_SVH
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define CCPC_CLK_HZ      20000000
`define CCPC_RING_HZ     1000000
`define CCPC_RING_CYC    (`CCPC_CLK_HZ / `CCPC_RING_HZ)
// ---------------------------------------------
// Register map
// ---------------------------------------------
`define CCPC_PROT_OFS    8'h00
`define CCPC_CM0_OFS     8'h04
`define CCPC_CM1_OFS     8'h08
`define CCPC_CM2_OFS     8'h0C
`define CCPC_PM2_OFS     8'h10
`define CCPC_CMD_OFS     8'h14
`define CCPC_STAT_OFS    8'h18
`define CCPC_WORD_MASK   8'hFC
`define CCPC_PROT_MASK   8'h03
`define CCPC_PM2_MASK    8'h06
`define CCPC_CM0_RST     8'h40
`define CCPC_RESP_OKAY   2'h0
`define CCPC_RESP_SLVERR 2'h2
// ---------------------------------------------
// Fields
// ---------------------------------------------
`define CCPC_PRC0        0
`define CCPC_MODE_REG_WRITE_ENABLE        1
`define CCPC_GATE        2
`define CCPC_HALT        5
`define CCPC_DIV8        6
`define CCPC_SYSSEL      7
`define CCPC_STOP        0
`define CCPC_B1          1
`define CCPC_DIVL        6
`define CCPC_DIVH        7
`define CCPC_OSDE        0
`define CCPC_RSEL        1
`define CCPC_LOCK        1
`define CCPC_WRS         2
`define CCPC_WAIT        0
`define CCPC_LOG_DIV8    3'h3
`define CCPC_LOG_DIV16   3'h4
`endif

/* File: ccpc_pkg.sv */
// Purpose: Types for CPU clock and power control
// Assumes: Constants come from ccpc_consts.svh
// Notes:   One packed struct holds all state
package ccpc_pkg;
  // ---------------------------------------------
  // Power state
  // ---------------------------------------------
  typedef enum logic [2:0] {
    CCPC_RUN  = 3'h1,
    CCPC_WAIT = 3'h2,
    CCPC_STOP = 3'h4
  } ccpc_pwr_t;

  // ---------------------------------------------
  // Whole block state
  // ---------------------------------------------
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [7:0]  w_data;
    logic        w_en;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  prot;
    logic [7:0]  cm0;
    logic [7:0]  cm1;
    logic [7:0]  cm2;
    logic [7:0]  pm2;
    ccpc_pwr_t   pwr;
    logic [1:0]  s_ext;
    logic [1:0]  s_int;
    logic [1:0]  s_hold;
    logic [7:0]  ring_cnt;
    logic        ring_run;
    logic [3:0]  cpu_cnt;
    logic [2:0]  div_cur;
    logic        sel_cur;
    logic [4:0]  p_cnt;
    logic        p_gate;
    logic        cpu_tick;
    logic        wdt_tick;
    logic [3:0]  f_tick;
    logic        gpio_hold;
  } ccpc_state_t;
endpackage

/* File: ccpc_top.sv */
// Purpose: CPU clock select, divide and power control
// Assumes: Clocks are one-cycle ticks on aclk
// Notes:   Main clock ticks every aclk, ring every 20
`timescale 1ns/1ps
`include "ccpc_consts.svh"

// Operation
// R1: Mode register two needs write enable
// R2: Lock and watchdog-ring bits are sticky
// R3: Lock keeps wait from halting bus clock
// R4: Lock blocks listed clock control writes
// R5: Watchdog-ring bit starts ring, feeds watchdog
// R6: Watchdog-ring bit blocks stop entry
// R7: Ring watchdog counts in wait, hold
// R8: Reset gives main clock divided by eight
// R9: Ring off at reset, select enables it
// R10: Divider gives 1, 2, 4, 8, 16
// R11: High, medium and ring speed modes
// R12: Stop entry forces divide by eight
// R13: Peripheral clocks divide by 1,2,8,32
// R14: Peripheral clocks gated in wait, low power
// R15: Software selects only a stable source
// R16: Set divide by eight before leaving ring
// R17: Wait stops CPU clock, oscillators run
// R18: Wake by reset or permitted interrupts
// R19: Port pins hold during wait
// R20: Reset-only wake needs all levels zero
// R21: Interrupt wake needs level, flag, enable
// R22: Wake resumes the same clock setting
// R23: Source and divider change glitch-free
// R24: Gating changes only between clock pulses
module ccpc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              awvalid,
  output      logic              awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output      logic              wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output      logic              bvalid,
  input  wire logic              bready,
  output      logic [1:0]        bresp,
  input  wire logic              arvalid,
  output      logic              arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output      logic              rvalid,
  input  wire logic              rready,
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  input  wire logic              irq_ext_wake,
  input  wire logic              irq_int_wake,
  input  wire logic              hold_req,
  output      logic              cpu_tick,
  output      logic              wdt_tick,
  output      logic [3:0]        timer_periph_clock,
  output      logic [3:0]        sio_periph_clock,
  output      logic              ring_osc_run,
  output      logic              gpio_hold
);

  // ---------------------------------------------
  // State and derived terms
  // ---------------------------------------------
  localparam logic [7:0] RING_LAST = 8'(`CCPC_RING_CYC - 1);

  ccpc_pkg::ccpc_state_t q;
  ccpc_pkg::ccpc_state_t n;

  logic       lock;
  logic       wrs;
  logic       ring_on;
  logic       ring_tick;
  logic       main_tick;
  logic       src_tick;
  logic       halt;
  logic       gate_want;
  logic [3:0] term;
  logic [2:0] new_div;
  logic [7:0] wd;
  logic [7:0] wa;
  logic [7:0] ra;

  assign lock = q.pm2[`CCPC_LOCK];
  assign wrs  = q.pm2[`CCPC_WRS];
  // Oscillators die in stop; ring also runs for the watchdog
  // Ring outlives its select bit until the source swap lands, else the swap never comes
  assign ring_on   = (q.cm2[`CCPC_RSEL] | q.sel_cur | wrs) & (q.pwr != ccpc_pkg::CCPC_STOP); // R5 R9
  assign ring_tick = ring_on & (q.ring_cnt == RING_LAST);
  assign main_tick = ~q.cm0[`CCPC_HALT] & (q.pwr != ccpc_pkg::CCPC_STOP);
  assign src_tick  = q.sel_cur ? ring_tick : main_tick; // R9 R11
  // Locked wait never reaches WAIT, so halt only in real wait or in stop
  assign halt = (q.pwr != ccpc_pkg::CCPC_RUN); // R17
  assign gate_want = ((q.pwr == ccpc_pkg::CCPC_WAIT) & q.cm0[`CCPC_GATE])
                   | (q.cm2[`CCPC_RSEL] & q.cm0[`CCPC_HALT]); // R14
  assign term = (4'h1 << q.div_cur) - 4'h1;
  assign new_div = q.cm0[`CCPC_DIV8] ? `CCPC_LOG_DIV8 :
                   (&q.cm1[`CCPC_DIVH:`CCPC_DIVL]) ? `CCPC_LOG_DIV16 :
                   {1'b0, q.cm1[`CCPC_DIVH], q.cm1[`CCPC_DIVL]}; // R10
  assign wd = q.w_data;
  assign wa = q.aw_addr & `CCPC_WORD_MASK;
  assign ra = 8'(araddr) & `CCPC_WORD_MASK;

  // ---------------------------------------------
  // Next state
  // ---------------------------------------------
  always_comb begin
    n = q;
    n.cpu_tick = 1'b0;
    n.wdt_tick = 1'b0;
    n.f_tick   = 4'h0;
    n.s_ext  = {q.s_ext[0], irq_ext_wake};
    n.s_int  = {q.s_int[0], irq_int_wake};
    n.s_hold = {q.s_hold[0], hold_req};

    // Bus: address and data may arrive in either order
    if (awvalid & q.awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = 8'(awaddr);
    end
    if (wvalid & q.wready) begin
      n.w_got  = 1'b1;
      n.w_data = wdata[7:0];
      n.w_en   = wstrb[0];
    end
    if (bready & q.bvalid) begin
      n.bvalid = 1'b0;
    end
    if (q.aw_got & q.w_got & ~q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `CCPC_RESP_OKAY;
      case (wa)
        `CCPC_PROT_OFS: begin
          if (q.w_en) n.prot = wd & `CCPC_PROT_MASK;
        end
        `CCPC_CM0_OFS: begin
          if (q.w_en & q.prot[`CCPC_PRC0]) begin
            n.cm0[`CCPC_DIV8] = wd[`CCPC_DIV8];
            if (~lock) begin // R4
              n.cm0[`CCPC_GATE]   = wd[`CCPC_GATE];
              n.cm0[`CCPC_HALT]   = wd[`CCPC_HALT];
              n.cm0[`CCPC_SYSSEL] = wd[`CCPC_SYSSEL];
            end
          end
        end
        `CCPC_CM1_OFS: begin
          if (q.w_en & q.prot[`CCPC_PRC0]) begin
            n.cm1[`CCPC_DIVH] = wd[`CCPC_DIVH];
            n.cm1[`CCPC_DIVL] = wd[`CCPC_DIVL];
            if (~lock) n.cm1[`CCPC_B1] = wd[`CCPC_B1]; // R4
            if (~lock & ~wrs & wd[`CCPC_STOP] & (q.pwr == ccpc_pkg::CCPC_RUN)) begin // R4 R6
              n.cm1[`CCPC_STOP] = 1'b1;
              n.pwr = ccpc_pkg::CCPC_STOP;
              n.cm0[`CCPC_DIV8] = 1'b1; // R12
            end
          end
        end
        `CCPC_CM2_OFS: begin
          if (q.w_en & q.prot[`CCPC_PRC0]) begin
            n.cm2[`CCPC_RSEL] = wd[`CCPC_RSEL]; // R9
            if (~lock) n.cm2[`CCPC_OSDE] = wd[`CCPC_OSDE]; // R4
          end
        end
        `CCPC_PM2_OFS: begin
          // Ones only accumulate until reset
          if (q.w_en & q.prot[`CCPC_MODE_REG_WRITE_ENABLE]) n.pm2 = q.pm2 | (wd & `CCPC_PM2_MASK); // R1 R2
        end
        `CCPC_CMD_OFS: begin
          if (q.w_en & wd[`CCPC_WAIT] & (q.pwr == ccpc_pkg::CCPC_RUN) & ~lock) begin // R3
            n.pwr = ccpc_pkg::CCPC_WAIT; // R17
          end
        end
        `CCPC_STAT_OFS: begin
        end
        default: n.bresp = `CCPC_RESP_SLVERR;
      endcase
    end

    // Bus: reads answer one cycle after the address
    if (rready & q.rvalid) begin
      n.rvalid = 1'b0;
    end
    if (arvalid & q.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `CCPC_RESP_OKAY;
      n.rdata  = 32'h0;
      case (ra)
        `CCPC_PROT_OFS: n.rdata[7:0] = q.prot;
        `CCPC_CM0_OFS:  n.rdata[7:0] = q.cm0;
        `CCPC_CM1_OFS:  n.rdata[7:0] = q.cm1;
        `CCPC_CM2_OFS:  n.rdata[7:0] = q.cm2;
        `CCPC_PM2_OFS:  n.rdata[7:0] = q.pm2;
        `CCPC_CMD_OFS:  n.rdata[7:0] = 8'h00;
        `CCPC_STAT_OFS: n.rdata[7:0] = {q.ring_run, q.sel_cur, q.div_cur, q.pwr}; // R11
        default:        n.rresp = `CCPC_RESP_SLVERR;
      endcase
    end

    // Wake; clock setting is untouched, so wait resumes as before and stop resumes at the divide by eight forced on entry
    case (q.pwr)
      ccpc_pkg::CCPC_RUN: begin
      end
      ccpc_pkg::CCPC_WAIT: begin
        if (q.s_ext[1] | (q.s_int[1] & ~q.cm0[`CCPC_GATE])) begin // R18
          n.pwr = ccpc_pkg::CCPC_RUN; // R22
        end
      end
      ccpc_pkg::CCPC_STOP: begin
        if (q.s_ext[1]) begin
          n.pwr = ccpc_pkg::CCPC_RUN;
          n.cm1[`CCPC_STOP] = 1'b0;
        end
      end
      default: n.pwr = ccpc_pkg::CCPC_RUN;
    endcase

    // Ring oscillator model
    if (ring_on) begin
      n.ring_cnt = ring_tick ? 8'h00 : q.ring_cnt + 8'h01;
    end else begin
      n.ring_cnt = 8'h00;
    end
    n.ring_run = ring_on; // R5

    // Source and divisor swap only at a period end
    if (src_tick) begin
      if (q.cpu_cnt == term) begin
        n.cpu_cnt  = 4'h0;
        n.div_cur  = new_div; // R10 R23
        n.sel_cur  = q.cm2[`CCPC_RSEL]; // R23
        n.cpu_tick = ~halt; // R17 R24
      end else begin
        n.cpu_cnt = q.cpu_cnt + 4'h1;
      end
      n.p_cnt = q.p_cnt + 5'h1;
      if (~q.p_gate) begin
        n.f_tick = {&q.p_cnt, &q.p_cnt[2:0], q.p_cnt[0], 1'b1}; // R13
      end
      // Gate moves only after the slowest clock completes
      if (&q.p_cnt) n.p_gate = gate_want; // R14 R24
    end

    // Stop freezes the divider; restart it cleanly at eight
    if ((n.pwr == ccpc_pkg::CCPC_STOP) & (q.pwr != ccpc_pkg::CCPC_STOP)) begin
      n.div_cur = `CCPC_LOG_DIV8; // R12
      n.cpu_cnt = 4'h0;
    end

    n.wdt_tick = wrs ? ring_tick : (n.cpu_tick & ~q.s_hold[1]); // R5 R7
    n.gpio_hold = (n.pwr != ccpc_pkg::CCPC_RUN); // R19

    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready  = ~n.w_got & ~n.bvalid;
    n.arready = ~n.rvalid;
  end

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.pwr     <= ccpc_pkg::CCPC_RUN;
      q.cm0     <= `CCPC_CM0_RST; // R8
      q.div_cur <= `CCPC_LOG_DIV8; // R8
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign awready            = q.awready;
  assign wready             = q.wready;
  assign bvalid             = q.bvalid;
  assign bresp              = q.bresp;
  assign arready            = q.arready;
  assign rvalid             = q.rvalid;
  assign rdata              = q.rdata;
  assign rresp              = q.rresp;
  assign cpu_tick           = q.cpu_tick;
  assign wdt_tick           = q.wdt_tick;
  assign timer_periph_clock = q.f_tick;
  assign sio_periph_clock   = q.f_tick;
  assign ring_osc_run       = q.ring_run;
  assign gpio_hold          = q.gpio_hold;

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sticky_lock_a: assert property (q.pm2[`CCPC_LOCK] |=> q.pm2[`CCPC_LOCK]) // R2
    else $error("lock bit cleared");
  sticky_wrs_a: assert property (q.pm2[`CCPC_WRS] |=> q.pm2[`CCPC_WRS]) // R2
    else $error("watchdog ring bit cleared");
  lock_wait_a: assert property ($rose(q.pwr == ccpc_pkg::CCPC_WAIT) |-> !$past(q.pm2[`CCPC_LOCK])) // R3
    else $error("wait entered while locked");
  stop_guard_a: assert property ($rose(q.pwr == ccpc_pkg::CCPC_STOP)
                                 |-> !$past(q.pm2[`CCPC_WRS]) && !$past(q.pm2[`CCPC_LOCK])) // R6
    else $error("stop entered while protected");
  stop_div8_a: assert property ($rose(q.pwr == ccpc_pkg::CCPC_STOP) |-> q.cm0[`CCPC_DIV8]) // R12
    else $error("stop without divide by eight");
  wait_cpu_off_a: assert property ((q.pwr == ccpc_pkg::CCPC_WAIT) ##1 (q.pwr == ccpc_pkg::CCPC_WAIT)
                                   |-> !q.cpu_tick) // R17
    else $error("cpu clock runs in wait");
  ring_wdt_a: assert property ((q.pm2[`CCPC_WRS] && q.pwr != ccpc_pkg::CCPC_STOP
                                && q.ring_cnt == RING_LAST) |=> q.wdt_tick) // R7
    else $error("ring watchdog tick missing");
  gate_off_a: assert property ($past(q.p_gate) && q.p_gate |-> q.f_tick == 4'h0) // R14
    else $error("peripheral clock while gated");
  f32_rate_a: assert property (q.f_tick[3] |-> q.f_tick[2] && q.f_tick[1] && q.f_tick[0]) // R13
    else $error("slow peripheral tick without fast");
  stop_div_a: assert property ((q.pwr == ccpc_pkg::CCPC_STOP) |-> (q.div_cur == `CCPC_LOG_DIV8)) // R12
    else $error("stop with active divisor not eight");
  pins_hold_a: assert property (q.gpio_hold == (q.pwr != ccpc_pkg::CCPC_RUN)) // R19
    else $error("pin hold does not follow power state");
  ring_run_a: assert property (((q.cm2[`CCPC_RSEL] || q.pm2[`CCPC_WRS]) && q.pwr != ccpc_pkg::CCPC_STOP) // R5
                               |=> q.ring_run)
    else $error("ring not running when requested");
  ring_off_a: assert property ((!q.cm2[`CCPC_RSEL] && !q.pm2[`CCPC_WRS] && !q.sel_cur) |=> !q.ring_run) // R9
    else $error("ring running when unused");
  lock_cfg_a: assert property ((q.pm2[`CCPC_LOCK] && $past(q.pm2[`CCPC_LOCK])) // R4
                               |-> $stable(q.cm0[`CCPC_GATE]) && $stable(q.cm0[`CCPC_HALT])
                                   && $stable(q.cm0[`CCPC_SYSSEL]) && $stable(q.cm1[`CCPC_B1]) && $stable(q.cm2[`CCPC_OSDE]))
    else $error("locked clock bit changed");
  div_legal_a: assert property (q.div_cur <= `CCPC_LOG_DIV16) // R10
    else $error("active divisor out of range");
  tick_phase_a: assert property (q.cpu_tick |-> (q.cpu_cnt == 4'h0)) // R10
    else $error("cpu tick off period boundary");
  wake_run_a: assert property ((q.pwr == ccpc_pkg::CCPC_WAIT && q.s_ext[1]) |=> (q.pwr == ccpc_pkg::CCPC_RUN)) // R18
    else $error("external wake ignored");
  gate_hold_a: assert property (!(&q.p_cnt) |=> $stable(q.p_gate)) // R24
    else $error("peripheral gate moved mid period");
  clk_swap_a: assert property (($changed(q.sel_cur) || $changed(q.div_cur)) // R23
                               |-> (q.cpu_cnt == 4'h0))
    else $error("clock setting changed mid period");
  wdt_hold_a: assert property ((!q.pm2[`CCPC_WRS] && q.s_hold[1]) |=> !q.wdt_tick) // R7
    else $error("cpu watchdog counts in hold");

endmodule // ccpc_top

/* File: cpu_clock_and_power_control_tb.sv */
// Purpose: Self-checking bench for ccpc_top
// Assumes: 20 MHz aclk, AXI4-Lite register access
// Notes:   Ring source period is 20 aclk cycles
`timescale 1ns/1ps
`include "ccpc_consts.svh"
module cpu_clock_and_power_control_tb;
  logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, irq_ext_wake = 1'h0, irq_int_wake = 1'h0, hold_req = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, cpu_tick, wdt_tick, ring_osc_run, gpio_hold;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [3:0]  timer_periph_clock, sio_periph_clock;
  int          miscompares = 0, tests_run = 0, cyc = 0, g, c;

  ccpc_top dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .irq_ext_wake(irq_ext_wake), .irq_int_wake(irq_int_wake),
    .hold_req(hold_req), .cpu_tick(cpu_tick), .wdt_tick(wdt_tick), .timer_periph_clock(timer_periph_clock),
    .sio_periph_clock(sio_periph_clock), .ring_osc_run(ring_osc_run), .gpio_hold(gpio_hold));

  always #25 aclk = ~aclk;

  // ---------------------------------------------
  // Closing and checks
  // ---------------------------------------------
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Generous ceiling; the whole run needs well under two thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    tests_run++;
    if (v !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask

  // ---------------------------------------------
  // Bus and clock helpers
  // ---------------------------------------------
  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    bit ta = 0, tw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        tw = 1;
        wvalid <= 1'h0;
      end
    end
    while (bvalid !== 1'h1) @(posedge aclk);
    rs = bresp;
    bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  // 0 cpu, 1 watchdog, 2..5 peripheral f1 f2 f8 f32
  function automatic logic tk(int s);
    case (s)
      0: return cpu_tick;
      1: return wdt_tick;
      default: return timer_periph_clock[s-2];
    endcase
  endfunction

  task automatic gap(input int s);
    int n = 0;
    do begin @(posedge aclk); n++; end while (tk(s) !== 1'h1 && n < 500);
    g = 0;
    do begin @(posedge aclk); g++; end while (tk(s) !== 1'h1 && g < 500);
  endtask

  task automatic cnt(input int s, input int n);
    c = 0;
    repeat (n) begin
      @(posedge aclk);
      if (tk(s) === 1'h1) c++;
    end
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_reset_vals();
    logic [7:0] ofs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
    logic [7:0] exv[6] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h19};
    rst();
    for (int i = 0; i < 6; i++) begin
      axi_rd(ofs[i]);
      chk("reset_reg", {24'h0, exv[i]}, rd);
    end
    chk("ring_off", 1'h0, ring_osc_run);
    gap(0);
    chk("reset_div8", 8, g);
    axi_rd(8'h1C);
    chk("unmapped_rd", `CCPC_RESP_SLVERR, rs);
    axi_wr(8'h1C, 8'h00);
    chk("unmapped_wr", `CCPC_RESP_SLVERR, rs);
  endtask

  task automatic t_divider();
    logic [7:0] v0[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
    logic [7:0] v1[5] = '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hC0};
    int         dv[5] = '{1, 2, 4, 16, 8};
    rst();
    axi_wr(`CCPC_PROT_OFS, 8'h01);
    for (int i = 0; i < 5; i++) begin
      axi_wr(`CCPC_CM1_OFS, v1[i]);
      axi_wr(`CCPC_CM0_OFS, v0[i]);
      gap(0);
      gap(0);
      chk("cpu_div", dv[i], g);
    end
  endtask

  task automatic t_ring();
    rst();
    axi_wr(`CCPC_PROT_OFS, 8'h01);
    axi_wr(`CCPC_CM0_OFS, 8'h00);
    axi_wr(`CCPC_CM2_OFS, 8'h02);
    gap(0);
    gap(0);
    chk("ring_div1", 20, g);
    chk("ring_on", 1'h1, ring_osc_run);
    axi_rd(`CCPC_STAT_OFS);
    chk("ring_stat", 32'hC1, rd);
    axi_wr(`CCPC_CM0_OFS, 8'h40);
    axi_wr(`CCPC_CM2_OFS, 8'h00);
    gap(0);
    gap(0);
    chk("back_main", 8, g);
  endtask

  task automatic t_stop();
    rst();
    axi_wr(`CCPC_PROT_OFS, 8'h01);
    axi_wr(`CCPC_CM0_OFS, 8'h00);
    axi_wr(`CCPC_CM1_OFS, 8'h01);
    axi_rd(`CCPC_STAT_OFS);
    chk("stop_stat", 32'h1C, rd & 32'h3F);
    axi_rd(`CCPC_CM0_OFS);
    chk("stop_div8", 32'h40, rd);
    irq_ext_wake <= 1'h1;
    repeat (10) @(posedge aclk);
    irq_ext_wake <= 1'h0;
    axi_rd(`CCPC_STAT_OFS);
    chk("stop_exit", 32'h1, rd & 32'h7);
  endtask

  task automatic t_wait();
    rst();
    axi_wr(`CCPC_PROT_OFS, 8'h01);
    axi_wr(`CCPC_CM1_OFS, 8'h40);
    axi_wr(`CCPC_CM0_OFS, 8'h04);
    axi_wr(`CCPC_CMD_OFS, 8'h01);
    axi_rd(`CCPC_STAT_OFS);
    chk("wait_stat", 32'h2, rd & 32'h7);
    chk("pins_hold", 1'h1, gpio_hold);
    cnt(0, 40);
    chk("wait_cpu", 0, c);
    cnt(2, 40);
    cnt(2, 40);
    chk("wait_gate", 0, c);
    irq_int_wake <= 1'h1;
    repeat (20) @(posedge aclk);
    irq_int_wake <= 1'h0;
    axi_rd(`CCPC_STAT_OFS);
    chk("int_masked", 32'h2, rd & 32'h7);
    irq_ext_wake <= 1'h1;
    repeat (10) @(posedge aclk);
    irq_ext_wake <= 1'h0;
    axi_rd(`CCPC_STAT_OFS);
    chk("ext_wake", 32'h1, rd & 32'h7);
    chk("pins_free", 1'h0, gpio_hold);
    gap(0);
    gap(0);
    chk("same_div", 2, g);
    axi_wr(`CCPC_CMD_OFS, 8'h01);
    repeat (20) @(posedge aclk);
    axi_rd(`CCPC_STAT_OFS);
    chk("no_wake", 32'h2, rd & 32'h7);
    rst();
    axi_rd(`CCPC_STAT_OFS);
    chk("reset_wake", 32'h1, rd & 32'h7);
  endtask

  task automatic t_wdt_ring();
    rst();
    axi_wr(`CCPC_PROT_OFS, 8'h03);
    axi_wr(`CCPC_PM2_OFS, 8'h04);
    axi_wr(`CCPC_PM2_OFS, 8'h00);
    axi_rd(`CCPC_PM2_OFS);
    chk("wrs_sticky", 32'h04, rd);
    chk("wrs_ring", 1'h1, ring_osc_run);
    axi_wr(`CCPC_CM1_OFS, 8'h01);
    axi_rd(`CCPC_STAT_OFS);
    chk("stop_block", 32'h1, rd & 32'h7);
    axi_rd(`CCPC_CM1_OFS);
    chk("stop_bit", 32'h0, rd & 32'h1);
    axi_wr(`CCPC_CMD_OFS, 8'h01);
    hold_req <= 1'h1;
    cnt(1, 100);
    chk("wdt_runs", 5, c);
    hold_req <= 1'h0;
    irq_int_wake <= 1'h1;
    repeat (10) @(posedge aclk);
    irq_int_wake <= 1'h0;
    axi_rd(`CCPC_STAT_OFS);
    chk("int_wake", 32'h1, rd & 32'h7);
  endtask

  task automatic t_lock();
    rst();
    axi_wr(`CCPC_PROT_OFS, 8'h01);
    axi_wr(`CCPC_PM2_OFS, 8'h02);
    axi_rd(`CCPC_PM2_OFS);
    chk("pm2_guard", 32'h0, rd);
    axi_wr(`CCPC_PROT_OFS, 8'h03);
    axi_wr(`CCPC_PM2_OFS, 8'h02);
    axi_wr(`CCPC_CM0_OFS, 8'h04);
    axi_rd(`CCPC_CM0_OFS);
    chk("lock_cm0", 32'h00, rd);
    axi_wr(`CCPC_CM2_OFS, 8'h01);
    axi_rd(`CCPC_CM2_OFS);
    chk("lock_cm2", 32'h0, rd);
    axi_wr(`CCPC_CMD_OFS, 8'h01);
    axi_rd(`CCPC_STAT_OFS);
    chk("lock_wait", 32'h1, rd & 32'h7);
    axi_wr(`CCPC_PM2_OFS, 8'h00);
    axi_rd(`CCPC_PM2_OFS);
    chk("lock_sticky", 32'h02, rd);
  endtask

  task automatic t_periph();
    int dv[4] = '{1, 2, 8, 32};
    rst();
    for (int i = 0; i < 4; i++) begin
      gap(i + 2);
      chk("periph_div", dv[i], g);
      chk("sio_same", timer_periph_clock, sio_periph_clock);
    end
  endtask

  initial begin
    t_reset_vals();
    t_divider();
    t_ring();
    t_stop();
    t_wait();
    t_wdt_ring();
    t_lock();
    t_periph();
    wrap_up();
  end
endmodule // cpu_clock_and_power_control_tb
